// [wmcsr_params.svh]
`ifndef WMCSR_PARAMS_SVH
`define WMCSR_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define WMC_IDX_FRM_OFFSET 8'h23
`define WMC_IDX_TX_STATUS 8'h24
`define WMC_IDX_BCN_CTRL 8'h25
`define WMC_IDX_CLK_GATE 8'h26
`define WMC_IDX_TURNAROUND 8'h27
`define WMC_IDX_HSYM_LOW 8'h28
`define WMC_IDX_HSYM_HIGH 8'h29
`define WMC_IDX_SOFT_RST 8'h2a
`define WMC_IDX_SEC_CTRL0 8'h2c
`define WMC_IDX_TX_STABLE 8'h2e
`define WMC_IDX_INT_STATUS 8'h31

// ==========================================================================
// Field positions
// ==========================================================================
`define WMC_B_RETRY_LO 6
`define WMC_B_CCA 5
`define WMC_B_G2_NOTIME 4
`define WMC_B_G1_NOTIME 3
`define WMC_B_G2_FAIL 2
`define WMC_B_G1_FAIL 1
`define WMC_B_N_FAIL 0
`define WMC_B_BCN_MASK 7
`define WMC_B_WAKE_CAUSE 6
`define WMC_B_RSSI_LO 4
`define WMC_B_GTS_CLK 3
`define WMC_B_TURN_LO 4
`define WMC_B_RST_PWR 2
`define WMC_B_RST_BB 1
`define WMC_B_RST_MAC 0
`define WMC_B_DEC_SKIP 7
`define WMC_B_DEC_GO 6
`define WMC_B_RX_SUITE_LO 3
`define WMC_B_TX_SUITE_LO 0
`define WMC_B_SETTLE_LO 4
`define WMC_B_INT_WAKE 6
`define WMC_B_INT_HSYM 5
`define WMC_B_INT_G2 2
`define WMC_B_INT_G1 1
`define WMC_B_INT_N 0

// ==========================================================================
// Reset values and limits
// ==========================================================================
`define WMC_RST_FRM_OFFSET 8'h00
`define WMC_RST_RSSI_SEL 2'h3
`define WMC_RST_RSSI_SYMS 4'h8
`define WMC_RST_TURN 4'h4
`define WMC_MIN_TURN 4'h2
`define WMC_RST_TURN_LOW 4'h8
`define WMC_RST_SETTLE 4'h7
`define WMC_RST_MSIFS 4'h5
`define WMC_RST_SUITE 3'h0

// ==========================================================================
// Timing and bus answers
// ==========================================================================
`define WMC_CLK_PERIOD_NS 10
`define WMC_HSYM_UNIT_US 8
`define WMC_HSYM_TICKS ((`WMC_HSYM_UNIT_US * 1000) / `WMC_CLK_PERIOD_NS)
`define WMC_RESP_OKAY 2'h0
`define WMC_RESP_SLVERR 2'h2

`endif

// [wmcsr_pkg.sv]
package wmcsr_pkg;

    // ======================================================================
    // Whole state of the register bank
    // ======================================================================
    typedef struct packed {
        logic [7:0] frm_offset;
        logic [1:0] n_retry;
        logic cca_busy;
        logic g2_notime;
        logic g1_notime;
        logic g2_fail;
        logic g1_fail;
        logic n_fail;
        logic bcn_mask;
        logic wake_cause;
        logic [1:0] rssi_sel;
        logic [3:0] rssi_syms;
        logic gts_clk;
        logic [3:0] turn;
        logic [3:0] turn_low;
        logic [15:0] hsym;
        logic [9:0] hsym_tick;
        logic hsym_exp;
        logic [2:0] srst;
        logic dec_skip;
        logic dec_go;
        logic [2:0] rx_suite;
        logic [2:0] tx_suite;
        logic [3:0] settle;
        logic [3:0] msifs;
        logic [7:0] int_flags;
        logic bcn_irq;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } wmcsr_state_t;

endpackage

// [wmcsr_regs.sv]
// How it works
// - Eight-bit read/write superframe offset, resets zero.
// - Bits 7-6 report normal FIFO retries.
// - Bit 5 shows channel busy on last send.
// - Bits 4/3 flag slot-time shortfall per slot FIFO.
// - Bits 2/1/0 flag retry-exceeded release failures.
// - Beacon mask bit suppresses beacon transmit interrupt.
// - Read-only bit 6 gives wake event cause.
// - Two-bit field picks 1/2/4/8 averaging symbols.
// - Bit 3 gates slot FIFO clock, resets off.
// - Four-bit turnaround, reset 4, never below 2.
// - Sixteen-bit half-symbol timer, 8 us units.
// - Writing bit 2 pulses power reset, self-clears.
// - Writing bit 1 pulses baseband reset, self-clears.
// - Writing bit 0 pulses link reset, self-clears.
// - Write-only bit 7 skips received frame decryption.
// - Write-only bit 6 starts received frame decryption.
// - Bits 5-3 select receive security suite.
// - Bits 2-0 select normal transmit security suite.
// - Four-bit oscillator settle time, reset 7.
// - Wake flag at status bit 6, read clears.
`timescale 1ns/1ps
`default_nettype none
`include "wmcsr_params.svh"

module wmcsr_regs
    import wmcsr_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int HSYM_TICKS = `WMC_HSYM_TICKS
)(
    input wire logic clk, // System clock, 100 MHz
    input wire logic resetn, // Asynchronous reset
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic txn_done, // Normal FIFO attempt sequence ended
    input wire logic [1:0] txn_retries, // Retries used by it
    input wire logic txn_fail, // Retry count exceeded
    input wire logic tx_cca_busy, // Channel found busy on that send
    input wire logic g1_done, // Slot 1 FIFO sequence ended
    input wire logic g1_fail, // Slot 1 retry count exceeded
    input wire logic g1_notime, // Slot 1 ran out of slot time
    input wire logic g2_done, // Slot 2 FIFO sequence ended
    input wire logic g2_fail, // Slot 2 retry count exceeded
    input wire logic g2_notime, // Slot 2 ran out of slot time
    input wire logic wake_evt, // Wake alert event pulse
    input wire logic wake_is_beacon, // Cause of that event
    input wire logic bcn_tx_irq_in, // Raw beacon FIFO interrupt
    output logic bcn_tx_irq, // Beacon FIFO interrupt after mask
    output logic [7:0] superframe_offset, // Slot boundary offset
    output logic [3:0] signal_average_symbols, // Symbols averaged
    output logic slot_fifo_clock_enable, // Slot FIFO clock gate
    output logic [3:0] turnaround_symbols, // Turnaround time
    output logic [3:0] oscillator_settle_symbols, // Settle time
    output logic [3:0] short_ifs_symbols, // Short spacing
    output logic [15:0] half_symbol_timer, // Timer value
    output logic half_symbol_expired, // Timer reached zero
    output logic power_mgmt_soft_reset, // Power reset pulse
    output logic baseband_soft_reset, // Baseband reset pulse
    output logic link_layer_soft_reset, // Link layer reset pulse
    output logic rx_decrypt_skip, // Skip decryption pulse
    output logic rx_decrypt_go, // Start decryption pulse
    output logic [2:0] rx_suite_select, // Receive security suite
    output logic [2:0] tx_normal_suite_select, // Transmit suite
    output logic [7:0] tx_status, // Transmit result status
    output logic [7:0] int_status // Interrupt status flags
);

    localparam logic [9:0] TICK_LAST = 10'(HSYM_TICKS - 1);

    wmcsr_state_t s_q;
    wmcsr_state_t s_d;
    logic w_hs;
    logic ar_hs;
    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic [7:0] wd;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    // ======================================================================
    // Bus handshakes
    // ======================================================================
    assign aw_idx = s_axi_awaddr[9:2];
    assign ar_idx = s_axi_araddr[9:2];
    assign wd = s_axi_wdata[7:0];
    assign s_axi_awready = ce & s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ce & ~s_q.rvalid;
    assign w_hs = s_axi_awready;
    assign ar_hs = s_axi_arready & s_axi_arvalid;

    assign tx_status = {s_q.n_retry, s_q.cca_busy, s_q.g2_notime,
        s_q.g1_notime, s_q.g2_fail, s_q.g1_fail, s_q.n_fail};

    // ======================================================================
    // Read mux
    // ======================================================================
    always_comb
    begin
        rd_ok = 1'b1;
        rd_val = 8'h00;
        unique case (ar_idx)
            `WMC_IDX_FRM_OFFSET: rd_val = s_q.frm_offset;
            `WMC_IDX_TX_STATUS: rd_val = tx_status;
            `WMC_IDX_BCN_CTRL: rd_val = {s_q.bcn_mask, s_q.wake_cause,
                s_q.rssi_sel, 4'h0};
            `WMC_IDX_CLK_GATE: rd_val = {4'h0, s_q.gts_clk, 3'h0};
            `WMC_IDX_TURNAROUND: rd_val = {s_q.turn, s_q.turn_low};
            `WMC_IDX_HSYM_LOW: rd_val = s_q.hsym[7:0];
            `WMC_IDX_HSYM_HIGH: rd_val = s_q.hsym[15:8];
            `WMC_IDX_SOFT_RST: rd_val = {5'h00, s_q.srst};
            `WMC_IDX_SEC_CTRL0: rd_val = {2'h0, s_q.rx_suite,
                s_q.tx_suite};
            `WMC_IDX_TX_STABLE: rd_val = {s_q.settle, s_q.msifs};
            `WMC_IDX_INT_STATUS: rd_val = s_q.int_flags;
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (aw_idx)
            `WMC_IDX_FRM_OFFSET, `WMC_IDX_TX_STATUS, `WMC_IDX_BCN_CTRL,
            `WMC_IDX_CLK_GATE, `WMC_IDX_TURNAROUND, `WMC_IDX_HSYM_LOW,
            `WMC_IDX_HSYM_HIGH, `WMC_IDX_SOFT_RST, `WMC_IDX_SEC_CTRL0,
            `WMC_IDX_TX_STABLE, `WMC_IDX_INT_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb
    begin
        s_d = s_q;
        s_d.srst = 3'h0;
        s_d.dec_skip = 1'b0;
        s_d.dec_go = 1'b0;
        s_d.hsym_exp = 1'b0;
        s_d.bcn_irq = bcn_tx_irq_in & ~s_q.bcn_mask;

        // Half-symbol countdown, one step per 8 us
        if (s_q.hsym != 16'h0000)
        begin
            if (s_q.hsym_tick == TICK_LAST)
            begin
                s_d.hsym_tick = 10'h000;
                s_d.hsym = s_q.hsym - 16'h0001;
                s_d.hsym_exp = (s_q.hsym == 16'h0001);
            end
            else
            begin
                s_d.hsym_tick = s_q.hsym_tick + 10'h001;
            end
        end
        else
        begin
            s_d.hsym_tick = 10'h000;
        end

        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = {24'h000000, rd_val};
            s_d.rresp = rd_ok ? `WMC_RESP_OKAY : `WMC_RESP_SLVERR;
            if (ar_idx == `WMC_IDX_INT_STATUS)
            begin
                s_d.int_flags = 8'h00;
            end
        end

        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        if (w_hs)
        begin
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? `WMC_RESP_OKAY : `WMC_RESP_SLVERR;
        end
        if (w_hs && s_axi_wstrb[0])
        begin
            unique case (aw_idx)
                `WMC_IDX_FRM_OFFSET: s_d.frm_offset = wd;
                `WMC_IDX_BCN_CTRL:
                begin
                    s_d.bcn_mask = wd[`WMC_B_BCN_MASK];
                    s_d.rssi_sel = wd[`WMC_B_RSSI_LO +: 2];
                    s_d.rssi_syms = 4'(4'h1 << wd[`WMC_B_RSSI_LO +: 2]);
                end
                `WMC_IDX_CLK_GATE: s_d.gts_clk = wd[`WMC_B_GTS_CLK];
                `WMC_IDX_TURNAROUND:
                begin
                    s_d.turn = (wd[`WMC_B_TURN_LO +: 4] < `WMC_MIN_TURN) ?
                        `WMC_MIN_TURN : wd[`WMC_B_TURN_LO +: 4];
                    s_d.turn_low = wd[3:0];
                end
                `WMC_IDX_HSYM_LOW:
                begin
                    s_d.hsym[7:0] = wd;
                    s_d.hsym_tick = 10'h000;
                end
                `WMC_IDX_HSYM_HIGH:
                begin
                    s_d.hsym[15:8] = wd;
                    s_d.hsym_tick = 10'h000;
                end
                `WMC_IDX_SOFT_RST:
                begin
                    s_d.srst = {wd[`WMC_B_RST_PWR], wd[`WMC_B_RST_BB],
                        wd[`WMC_B_RST_MAC]};
                end
                `WMC_IDX_SEC_CTRL0:
                begin
                    s_d.dec_skip = wd[`WMC_B_DEC_SKIP];
                    s_d.dec_go = wd[`WMC_B_DEC_GO];
                    s_d.rx_suite = wd[`WMC_B_RX_SUITE_LO +: 3];
                    s_d.tx_suite = wd[`WMC_B_TX_SUITE_LO +: 3];
                end
                `WMC_IDX_TX_STABLE:
                begin
                    s_d.settle = wd[`WMC_B_SETTLE_LO +: 4];
                    s_d.msifs = wd[3:0];
                end
                default:
                begin
                end
            endcase
        end

        // Events come last so a set beats a same-cycle read clear
        if (txn_done)
        begin
            s_d.n_retry = txn_retries;
            s_d.n_fail = txn_fail;
            s_d.cca_busy = tx_cca_busy;
            s_d.int_flags[`WMC_B_INT_N] = 1'b1;
        end
        if (g1_done)
        begin
            s_d.g1_fail = g1_fail;
            s_d.g1_notime = g1_notime;
            s_d.cca_busy = tx_cca_busy;
            s_d.int_flags[`WMC_B_INT_G1] = 1'b1;
        end
        if (g2_done)
        begin
            s_d.g2_fail = g2_fail;
            s_d.g2_notime = g2_notime;
            s_d.cca_busy = tx_cca_busy;
            s_d.int_flags[`WMC_B_INT_G2] = 1'b1;
        end
        if (wake_evt)
        begin
            s_d.wake_cause = wake_is_beacon;
            s_d.int_flags[`WMC_B_INT_WAKE] = 1'b1;
        end
        if (s_d.hsym_exp)
        begin
            s_d.int_flags[`WMC_B_INT_HSYM] = 1'b1;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.frm_offset <= `WMC_RST_FRM_OFFSET;
            s_q.rssi_sel <= `WMC_RST_RSSI_SEL;
            s_q.rssi_syms <= `WMC_RST_RSSI_SYMS;
            s_q.turn <= `WMC_RST_TURN;
            s_q.turn_low <= `WMC_RST_TURN_LOW;
            s_q.settle <= `WMC_RST_SETTLE;
            s_q.msifs <= `WMC_RST_MSIFS;
            s_q.rx_suite <= `WMC_RST_SUITE;
            s_q.tx_suite <= `WMC_RST_SUITE;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = s_q.rdata;
    assign bcn_tx_irq = s_q.bcn_irq;
    assign superframe_offset = s_q.frm_offset;
    assign signal_average_symbols = s_q.rssi_syms;
    assign slot_fifo_clock_enable = s_q.gts_clk;
    assign turnaround_symbols = s_q.turn;
    assign oscillator_settle_symbols = s_q.settle;
    assign short_ifs_symbols = s_q.msifs;
    assign half_symbol_timer = s_q.hsym;
    assign half_symbol_expired = s_q.hsym_exp;
    assign power_mgmt_soft_reset = s_q.srst[2];
    assign baseband_soft_reset = s_q.srst[1];
    assign link_layer_soft_reset = s_q.srst[0];
    assign rx_decrypt_skip = s_q.dec_skip;
    assign rx_decrypt_go = s_q.dec_go;
    assign rx_suite_select = s_q.rx_suite;
    assign tx_normal_suite_select = s_q.tx_suite;
    assign int_status = s_q.int_flags;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic wr_frm;
    logic wr_srst_pwr;
    logic wr_sec0;
    logic [2:0] wd_rx_suite;
    assign wr_frm = ce && w_hs && s_axi_wstrb[0] &&
        aw_idx == `WMC_IDX_FRM_OFFSET;
    assign wr_srst_pwr = ce && w_hs && s_axi_wstrb[0] &&
        aw_idx == `WMC_IDX_SOFT_RST && wd[`WMC_B_RST_PWR];
    assign wr_sec0 = ce && w_hs && s_axi_wstrb[0] &&
        aw_idx == `WMC_IDX_SEC_CTRL0;
    assign wd_rx_suite = wd[`WMC_B_RX_SUITE_LO +: 3];

    sequence pwr_req_s;
        wr_srst_pwr ##1 (ce && !wr_srst_pwr);
    endsequence
    sequence pwr_pulse_s;
        power_mgmt_soft_reset ##1 !power_mgmt_soft_reset;
    endsequence

    frm_offset_write_a: assert property (
        wr_frm |=> superframe_offset == $past(wd))
        else $error("superframe offset did not take the write");
    retry_capture_a: assert property (
        ce && txn_done |=> tx_status[7:6] == $past(txn_retries))
        else $error("retry count not captured at normal completion");
    cca_capture_a: assert property (
        ce && txn_done && !g1_done && !g2_done
        |=> tx_status[`WMC_B_CCA] == $past(tx_cca_busy))
        else $error("channel busy flag not captured");
    slot1_notime_a: assert property (
        ce && g1_done |=> tx_status[`WMC_B_G1_NOTIME] == $past(g1_notime))
        else $error("slot 1 time shortfall flag wrong");
    beacon_mask_a: assert property (
        ce && bcn_tx_irq_in && s_q.bcn_mask && !w_hs |=> !bcn_tx_irq)
        else $error("masked beacon interrupt passed");
    turn_floor_a: assert property (
        turnaround_symbols >= `WMC_MIN_TURN)
        else $error("turnaround below its floor");
    power_reset_pulse_a: assert property (
        pwr_req_s |-> pwr_pulse_s)
        else $error("power reset did not pulse and clear");
    wake_flag_set_a: assert property (
        ce && wake_evt |=> int_status[`WMC_B_INT_WAKE] ##0
        $past(wake_is_beacon) == s_q.wake_cause)
        else $error("wake flag or cause not set");
    rx_suite_write_a: assert property (
        wr_sec0 |=> rx_suite_select == $past(wd_rx_suite))
        else $error("receive suite did not take the write");
    hsym_step_a: assert property (
        ce && s_q.hsym != 16'h0000 && s_q.hsym_tick == TICK_LAST &&
        !(w_hs && (aw_idx == `WMC_IDX_HSYM_LOW ||
        aw_idx == `WMC_IDX_HSYM_HIGH))
        |=> half_symbol_timer == 16'($past(half_symbol_timer) - 16'h0001))
        else $error("half-symbol timer did not step");

endmodule // wmcsr_regs
`default_nettype wire

// [wmcsr_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module wmcsr_regs_bench;
    typedef struct packed {logic w; logic [7:0] i, d, e; logic [1:0] r;} wmcsr_row_t;
    // ==========================================================
    // Stimulus, outputs and design
    // ==========================================================
    logic clk = 0, resetn = 0, ce = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] ev = 0;
    logic [1:0] retries = 0;
    logic nfail = 0, cca = 0, g1f = 0, g1n = 0, g2f = 0, g2n = 0;
    logic wcause = 0, birq = 0;
    logic [3:0] strb = 4'h1;
    wire logic awready, wready, bvalid, arready, rvalid, irq, expired, gts;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [3:0] avg, turn;
    wire logic [15:0] tmr;
    wire logic [7:0] sfo, txst, ints;
    wire logic [3:0] stl, sifs;
    wire logic [2:0] rxs, txs;
    wire logic [4:0] p;
    int bad_count = 0, n_checks = 0, hits = 0, n, h0;
    wmcsr_row_t rows [16] = '{
        {1'b0, 8'h23, 8'h00, 8'h00, 2'h0},
        {1'b0, 8'h24, 8'h00, 8'h00, 2'h0},
        {1'b0, 8'h25, 8'h00, 8'h30, 2'h0},
        {1'b0, 8'h26, 8'h00, 8'h00, 2'h0},
        {1'b0, 8'h27, 8'h00, 8'h48, 2'h0},
        {1'b0, 8'h2c, 8'h00, 8'h00, 2'h0},
        {1'b0, 8'h2e, 8'h00, 8'h75, 2'h0},
        {1'b0, 8'h28, 8'h00, 8'h00, 2'h0},
        {1'b1, 8'h23, 8'h15, 8'h15, 2'h0},
        {1'b1, 8'h26, 8'hff, 8'h08, 2'h0},
        {1'b1, 8'h27, 8'h38, 8'h38, 2'h0},
        {1'b1, 8'h27, 8'h08, 8'h28, 2'h0},
        {1'b1, 8'h2c, 8'hff, 8'h3f, 2'h0},
        {1'b1, 8'h2e, 8'h95, 8'h95, 2'h0},
        {1'b1, 8'h24, 8'hff, 8'h00, 2'h0},
        {1'b1, 8'h30, 8'h55, 8'h00, 2'h2}};

    wmcsr_regs #(.HSYM_TICKS(4)) u_wmcsr_regs (
        .clk, .resetn, .ce, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .txn_done(ev[0]), .txn_retries(retries),
        .txn_fail(nfail), .tx_cca_busy(cca), .g1_done(ev[1]), .g1_fail(g1f),
        .g1_notime(g1n), .g2_done(ev[2]), .g2_fail(g2f), .g2_notime(g2n),
        .wake_evt(ev[3]), .wake_is_beacon(wcause), .bcn_tx_irq_in(birq),
        .bcn_tx_irq(irq), .superframe_offset(sfo),
        .signal_average_symbols(avg),
        .slot_fifo_clock_enable(gts), .turnaround_symbols(turn),
        .oscillator_settle_symbols(stl), .short_ifs_symbols(sifs),
        .half_symbol_timer(tmr), .half_symbol_expired(expired),
        .power_mgmt_soft_reset(p[4]), .baseband_soft_reset(p[3]),
        .link_layer_soft_reset(p[2]), .rx_decrypt_skip(p[1]),
        .rx_decrypt_go(p[0]), .rx_suite_select(rxs),
        .tx_normal_suite_select(txs), .tx_status(txst), .int_status(ints));

    initial forever #5 clk = ~clk;
    always @(posedge clk) hits <= hits + $countones(p);
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r = 2'h0);
        int k;
        k = 0;
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (!(awready && wready) && ++k < 99);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (!bvalid && ++k < 99);
        bready <= 1'b0;
        chk({k >= 99, bresp}, {1'b0, r});
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e,
                      input logic [1:0] r);
        int k;
        k = 0;
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready && ++k < 99);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid && ++k < 99);
        rready <= 1'b0;
        chk({rresp, rdata}, {r, 24'h0, e});
        @(posedge clk);
    endtask
    task automatic pulse(input logic [3:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (rows[k])
        begin
            if (rows[k].w) wr(rows[k].i, rows[k].d, rows[k].r);
            rd(rows[k].i, rows[k].e, rows[k].r);
        end
        chk({gts, turn, rxs, txs}, 11'h4bf);
        chk({sfo, stl, sifs}, 16'h1595);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h25, {2'h0, k[1:0], 4'h0});
            chk(avg, 1 << k);
        end
        wr(8'h25, 8'hb0);
        {retries, nfail, cca, g1f, g2n, wcause} <= 7'h7f;
        pulse(4'hf);
        chk({txst, ints}, 16'hf347);
        rd(8'h24, 8'hf3, 2'h0);
        rd(8'h25, 8'hf0, 2'h0);
        rd(8'h31, 8'h47, 2'h0);
        rd(8'h31, 8'h00, 2'h0);
        {retries, nfail, cca} <= 4'h0;
        pulse(4'h1);
        rd(8'h24, 8'h12, 2'h0);
        birq <= 1'b1;
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h25, 8'h30);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        h0 = hits;
        wr(8'h2a, 8'h07);
        wr(8'h2c, 8'hc0);
        @(posedge clk);
        chk(hits - h0, 5);
        rd(8'h2a, 8'h00, 2'h0);
        wr(8'h28, 8'h03);
        n = 0;
        while (!expired && n < 99) @(posedge clk) n++;
        chk({n >= 8 && n <= 16, tmr}, 17'h10000);
        rd(8'h31, 8'h21, 2'h0);
        ce <= 1'b0;
        pulse(4'h8);
        ce <= 1'b1;
        chk(ints, 8'h00);
        strb <= 4'h0;
        wr(8'h23, 8'h5a);
        strb <= 4'h1;
        rd(8'h23, 8'h15, 2'h0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk({gts, turn, rxs, txs}, 11'h100);
        rd(8'h23, 8'h00, 2'h0);
        finish_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
endmodule // wmcsr_regs_bench
`default_nettype wire
